/* pcd_pkg.sv */
// constants and types shared by the context-entry decoder files
// assumes a 32-bit ahb-lite register bus and one 20 mhz clock
package pcd_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CAP       = 8'h00;
  localparam logic [7:0] OFS_ENTRY     = 8'h04;
  localparam logic [7:0] OFS_EFFECTIVE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h14;

  // capability register bit positions
  localparam int CAP_PASID    = 0;
  localparam int CAP_NESTING  = 1;
  localparam int CAP_PAGE_REQ = 2;
  localparam int CAP_DEFER    = 3;
  localparam int CAP_W        = 4;

  // context entry low word bit positions
  localparam int ENT_PRESENT    = 0;
  localparam int ENT_FAULT_OFF  = 1;
  localparam int ENT_TT_LO      = 2;
  localparam int ENT_TT_HI      = 4;
  localparam int ENT_MEMTYPE_LO = 5;
  localparam int ENT_MEMTYPE_HI = 7;
  localparam int ENT_DEFER_EN   = 8;
  localparam int ENT_PRE        = 9;
  localparam int ENT_NESTING_EN = 10;
  localparam int ENT_PASID_EN   = 11;
  localparam int ENT_W          = 12;

  // index of each qualified control bit inside the qualifier vectors
  localparam int Q_DEFER   = 0;
  localparam int Q_PRE     = 1;
  localparam int Q_NESTING = 2;
  localparam int Q_PASID   = 3;
  localparam int Q_W       = 4;

  // effective register bit positions
  localparam int EFF_PASID      = 0;
  localparam int EFF_NESTING    = 1;
  localparam int EFF_PRE        = 2;
  localparam int EFF_DEFER      = 3;
  localparam int EFF_FIRST_ONLY = 4;
  localparam int EFF_NESTED     = 5;
  localparam int EFF_FAULT_OFF  = 6;
  localparam int EFF_PRESENT    = 7;

  // interrupt event bit positions
  localparam int EV_PASID_BLK = 0;
  localparam int EV_PREQ_BLK  = 1;
  localparam int EV_SUPD_BLK  = 2;
  localparam int EV_NP_BLK    = 3;
  localparam int EV_W         = 4;

  // reset values
  localparam logic [CAP_W-1:0] RST_CAP    = 4'hf;
  localparam logic [ENT_W-1:0] RST_ENTRY  = 12'h000;
  localparam logic [EV_W-1:0]  RST_IRQ_EN = 4'h0;

  // request kinds presented by the i/o side
  typedef enum logic [1:0] {
    PCD_KIND_DMA,
    PCD_KIND_PAGE_REQ,
    PCD_KIND_STATE_UPD,
    PCD_KIND_RSVD
  } pcd_kind_t;

  // how an accepted request is to be walked
  typedef enum logic [1:0] {
    PCD_WALK_NONE,
    PCD_WALK_LEGACY,
    PCD_WALK_FIRST_ONLY,
    PCD_WALK_NESTED
  } pcd_walk_t;

endpackage

/* pcd_qual_if.sv */
// carrier between the decoder and its reserved-bit qualifiers
// assumes one instance per decoder; each qualifier drives one bit of eff
interface pcd_qual_if;
  logic [pcd_pkg::Q_W-1:0] raw;
  logic [pcd_pkg::Q_W-1:0] cap;
  logic [pcd_pkg::Q_W-1:0] gate;
  logic [pcd_pkg::Q_W-1:0] eff;

  modport qual
  (
    input  raw,
    input  cap,
    input  gate,
    output eff
  );

  modport ctl
  (
    output raw,
    output cap,
    output gate,
    input  eff
  );
endinterface

/* pcd_bit_qual.sv */
// one entry control bit reduced to its effective value
// assumes cap and gate are already combined by the decoder
module pcd_bit_qual #(
  parameter int IDX = 0
)
(
  pcd_qual_if.qual q
);
  // an unsupported or gated-off bit behaves exactly like a stored zero
  assign q.eff[IDX] = q.raw[IDX] & q.cap[IDX] & q.gate[IDX];
endmodule

/* pcd_ctx_decode.sv */
// pasid control decode of an extended context entry, ahb-lite slave
// assumes a single master, single word transfers, one clock sys_clk
// request inputs come from logic on the same clock and need no synchroniser

// Summary of operation
// - no pasid capability: enable bit reads zero
// - pasid enable clear: block pasid requests
// - pasid enable set: process per type, nesting
// - no nesting capability: nested bit reads zero
// - nested and deferred bits ignored without pasid
// - nested clear: first-level translation only
// - nested set: first then second level
// - page request bit zero if unsupported type
// - page requests allowed only when enabled
// - no deferred capability: deferred bit reads zero
// - deferred clear: block state update messages
// - deferred set: process via state table
// - entry absent: only fault disable honoured
module pcd_ctx_decode
(
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  input  wire logic                      req_valid,
  input  wire logic                      req_has_pasid,
  input  wire pcd_pkg::pcd_kind_t        req_kind,
  output logic                           rsp_valid,
  output logic                           rsp_block,
  output pcd_pkg::pcd_walk_t             rsp_walk,
  output logic                           rsp_use_state_table,
  output logic                           rsp_fault_report,
  output logic                           irq
);

  // all state lives in one struct: one always_comb builds st_nxt,
  // one always_ff registers it.
  // cap      - capability bits software may lower to model a smaller unit
  // entry    - low control word of the context entry, stored as written
  // irq_*    - sticky event bits and their enables
  // dph_*    - write captured in the address phase, applied one cycle later
  // rdata    - read data registered in the address phase
  // rsp_*    - decision for the request seen on the previous edge
  typedef struct packed {
    logic [pcd_pkg::CAP_W-1:0] cap;
    logic [pcd_pkg::ENT_W-1:0] entry;
    logic [pcd_pkg::EV_W-1:0]  irq_stat;
    logic [pcd_pkg::EV_W-1:0]  irq_en;
    logic                      dph_wr;
    logic [7:0]                dph_addr;
    logic [31:0]               rdata;
    logic                      rsp_valid;
    logic                      rsp_block;
    pcd_pkg::pcd_walk_t        rsp_walk;
    logic                      rsp_state;
    logic                      rsp_fault;
  } pcd_state_t;

  pcd_state_t st_r;
  pcd_state_t st_nxt;

  pcd_qual_if qif ();

  logic                        present;
  logic                        tt_has_devtlb;
  logic [pcd_pkg::Q_W-1:0]     eff;
  logic [pcd_pkg::ENT_W-1:0]   entry_view;
  logic [31:0]                 eff_word;
  logic                        addr_phase;
  logic [pcd_pkg::EV_W-1:0]    events;
  logic                        blk;
  pcd_pkg::pcd_walk_t          walk;

  genvar gi;
  generate
    for (gi = 0; gi < pcd_pkg::Q_W; gi++)
    begin : g_qual
      pcd_bit_qual #(
        .IDX (gi)
      ) u_qual (
        .q (qif.qual)
      );
    end
  endgenerate

  assign present       = st_r.entry[pcd_pkg::ENT_PRESENT];
  // odd translation types are the ones that allow device-tlbs
  assign tt_has_devtlb = st_r.entry[pcd_pkg::ENT_TT_LO];

  // the stored bits are never altered by the qualifiers: lowering a
  // capability hides a bit, raising it again brings the stored value back.
  // this costs nothing and lets software probe capabilities safely.
  assign qif.raw[pcd_pkg::Q_PASID]    = st_r.entry[pcd_pkg::ENT_PASID_EN];
  assign qif.raw[pcd_pkg::Q_NESTING]  = st_r.entry[pcd_pkg::ENT_NESTING_EN];
  assign qif.raw[pcd_pkg::Q_PRE]      = st_r.entry[pcd_pkg::ENT_PRE];
  assign qif.raw[pcd_pkg::Q_DEFER]    = st_r.entry[pcd_pkg::ENT_DEFER_EN];
  assign qif.cap[pcd_pkg::Q_PASID]    = st_r.cap[pcd_pkg::CAP_PASID];
  assign qif.cap[pcd_pkg::Q_NESTING]  = st_r.cap[pcd_pkg::CAP_NESTING];
  assign qif.cap[pcd_pkg::Q_PRE]      = st_r.cap[pcd_pkg::CAP_PAGE_REQ] & tt_has_devtlb;
  assign qif.cap[pcd_pkg::Q_DEFER]    = st_r.cap[pcd_pkg::CAP_DEFER];
  // an absent entry forces every qualified control bit to its inert value
  assign qif.gate[pcd_pkg::Q_PASID]   = present;
  assign qif.gate[pcd_pkg::Q_PRE]     = present;
  // nesting and deferred invalidation only mean something under pasid;
  // the gate reads the already qualified pasid bit, so there is no loop:
  // that bit depends on raw, cap and present alone
  assign qif.gate[pcd_pkg::Q_NESTING] = present & qif.eff[pcd_pkg::Q_PASID];
  assign qif.gate[pcd_pkg::Q_DEFER]   = present & qif.eff[pcd_pkg::Q_PASID];
  assign eff = qif.eff;

  // readback shows unsupported bits as zero, everything else as stored
  // note: readback is not gated by present or pasid, only by capability
  // and type, so software reads what it wrote whenever it is supported
  always_comb
  begin
    entry_view = st_r.entry;
    entry_view[pcd_pkg::ENT_PASID_EN]   = st_r.entry[pcd_pkg::ENT_PASID_EN]
                                          & st_r.cap[pcd_pkg::CAP_PASID];
    entry_view[pcd_pkg::ENT_NESTING_EN] = st_r.entry[pcd_pkg::ENT_NESTING_EN]
                                          & st_r.cap[pcd_pkg::CAP_NESTING];
    entry_view[pcd_pkg::ENT_PRE]        = st_r.entry[pcd_pkg::ENT_PRE]
                                          & st_r.cap[pcd_pkg::CAP_PAGE_REQ]
                                          & tt_has_devtlb;
    entry_view[pcd_pkg::ENT_DEFER_EN]   = st_r.entry[pcd_pkg::ENT_DEFER_EN]
                                          & st_r.cap[pcd_pkg::CAP_DEFER];
  end

  // effective view: what the request decision below really uses
  always_comb
  begin
    eff_word = 32'h0000_0000;
    eff_word[pcd_pkg::EFF_PASID]      = eff[pcd_pkg::Q_PASID];
    eff_word[pcd_pkg::EFF_NESTING]    = eff[pcd_pkg::Q_NESTING];
    eff_word[pcd_pkg::EFF_PRE]        = eff[pcd_pkg::Q_PRE];
    eff_word[pcd_pkg::EFF_DEFER]      = eff[pcd_pkg::Q_DEFER];
    eff_word[pcd_pkg::EFF_FIRST_ONLY] = eff[pcd_pkg::Q_PASID] & ~eff[pcd_pkg::Q_NESTING];
    eff_word[pcd_pkg::EFF_NESTED]     = eff[pcd_pkg::Q_PASID] & eff[pcd_pkg::Q_NESTING];
    // fault disable is honoured even for an absent entry
    eff_word[pcd_pkg::EFF_FAULT_OFF]  = st_r.entry[pcd_pkg::ENT_FAULT_OFF];
    eff_word[pcd_pkg::EFF_PRESENT]    = present;
  end

  // request decision, one per valid cycle
  // the decision is purely combinational on the registered entry, so a
  // request right after an entry write sees the new entry.
  // unused request fields (pasid on page requests, for one) are ignored.
  always_comb
  begin
    blk    = 1'b0;
    walk   = pcd_pkg::PCD_WALK_NONE;
    events = '0;
    if (req_valid)
    begin
      if (!present)
      begin
        blk = 1'b1;
        events[pcd_pkg::EV_NP_BLK] = 1'b1;
      end
      else
      begin
        case (req_kind)
          pcd_pkg::PCD_KIND_DMA:
          begin
            if (!req_has_pasid)
              walk = pcd_pkg::PCD_WALK_LEGACY;
            else if (!eff[pcd_pkg::Q_PASID])
            begin
              blk = 1'b1;
              events[pcd_pkg::EV_PASID_BLK] = 1'b1;
            end
            else if (eff[pcd_pkg::Q_NESTING])
              walk = pcd_pkg::PCD_WALK_NESTED;
            else
              walk = pcd_pkg::PCD_WALK_FIRST_ONLY;
          end
          pcd_pkg::PCD_KIND_PAGE_REQ:
          begin
            if (!eff[pcd_pkg::Q_PRE])
            begin
              blk = 1'b1;
              events[pcd_pkg::EV_PREQ_BLK] = 1'b1;
            end
          end
          pcd_pkg::PCD_KIND_STATE_UPD:
          begin
            if (!eff[pcd_pkg::Q_DEFER])
            begin
              blk = 1'b1;
              events[pcd_pkg::EV_SUPD_BLK] = 1'b1;
            end
          end
          default:
          begin
            // unknown kinds are never allowed through
            blk = 1'b1;
          end
        endcase
      end
    end
  end

  // ahb-lite slave with no wait states: the address phase is taken when
  // selected with a nonseq or seq transfer while the bus is ready.
  // hsize is not checked; narrow writes are treated as whole words.
  assign addr_phase = hsel & htrans[1] & hready;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp_valid = req_valid;
    st_nxt.rsp_block = blk;
    st_nxt.rsp_walk  = walk;
    st_nxt.rsp_state = req_valid & ~blk & (req_kind == pcd_pkg::PCD_KIND_STATE_UPD);
    // faults of an absent entry still obey the fault disable bit
    st_nxt.rsp_fault = blk & ~st_r.entry[pcd_pkg::ENT_FAULT_OFF];

    // data phase of a write
    st_nxt.dph_wr = 1'b0;
    if (st_r.dph_wr)
    begin
      case (st_r.dph_addr)
        pcd_pkg::OFS_CAP:    st_nxt.cap    = hwdata[pcd_pkg::CAP_W-1:0];
        pcd_pkg::OFS_ENTRY:  st_nxt.entry  = hwdata[pcd_pkg::ENT_W-1:0];
        pcd_pkg::OFS_IRQ_EN: st_nxt.irq_en = hwdata[pcd_pkg::EV_W-1:0];
        pcd_pkg::OFS_IRQ_CLR:
          st_nxt.irq_stat = st_r.irq_stat & ~hwdata[pcd_pkg::EV_W-1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_nxt.irq_stat = st_nxt.irq_stat | events;

    // address phase: reads are sampled here so hrdata is a flop
    st_nxt.rdata = 32'h0000_0000;
    if (addr_phase)
    begin
      st_nxt.dph_wr   = hwrite;
      st_nxt.dph_addr = {haddr[7:2], 2'b00};
      if (!hwrite)
      begin
        case ({haddr[7:2], 2'b00})
          pcd_pkg::OFS_CAP:       st_nxt.rdata = {28'h0000000, st_r.cap};
          pcd_pkg::OFS_ENTRY:     st_nxt.rdata = {20'h00000, entry_view};
          pcd_pkg::OFS_EFFECTIVE: st_nxt.rdata = eff_word;
          pcd_pkg::OFS_IRQ_STAT:  st_nxt.rdata = {28'h0000000, st_r.irq_stat};
          pcd_pkg::OFS_IRQ_EN:    st_nxt.rdata = {28'h0000000, st_r.irq_en};
          default:                st_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // synchronous reset; only constants in the reset branch.
  // a write that lands in the reset cycle is lost, which is intended.
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      st_r.cap       <= pcd_pkg::RST_CAP;
      st_r.entry     <= pcd_pkg::RST_ENTRY;
      st_r.irq_stat  <= '0;
      st_r.irq_en    <= pcd_pkg::RST_IRQ_EN;
      st_r.dph_wr    <= 1'b0;
      st_r.dph_addr  <= 8'h00;
      st_r.rdata     <= 32'h0000_0000;
      st_r.rsp_valid <= 1'b0;
      st_r.rsp_block <= 1'b0;
      st_r.rsp_walk  <= pcd_pkg::PCD_WALK_NONE;
      st_r.rsp_state <= 1'b0;
      st_r.rsp_fault <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // zero wait states, every access answered okay
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign hrdata              = st_r.rdata;
  assign rsp_valid           = st_r.rsp_valid;
  assign rsp_block           = st_r.rsp_block;
  assign rsp_walk            = st_r.rsp_walk;
  assign rsp_use_state_table = st_r.rsp_state;
  assign rsp_fault_report    = st_r.rsp_fault;
  assign irq                 = |(st_r.irq_stat & st_r.irq_en);

endmodule

/* pcd_ctx_decode_chk.sv */
// port-level checks of the context-entry decoder
// assumes one clock sys_clk and the synchronous active-low nrst
module pcd_ctx_decode_chk
(
  input wire logic               sys_clk,
  input wire logic               nrst,
  input wire logic               hsel,
  input wire logic [31:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic [2:0]         hsize,
  input wire logic [31:0]        hwdata,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [31:0]        hrdata,
  input wire logic               req_valid,
  input wire logic               req_has_pasid,
  input wire pcd_pkg::pcd_kind_t req_kind,
  input wire logic               rsp_valid,
  input wire logic               rsp_block,
  input wire pcd_pkg::pcd_walk_t rsp_walk,
  input wire logic               rsp_use_state_table,
  input wire logic               rsp_fault_report,
  input wire logic               irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  wire dma = req_valid && req_kind == pcd_pkg::PCD_KIND_DMA;

  rsp_pulse_a: assert property (req_valid |=> rsp_valid)
    else $error("request not answered one cycle later");
  pasid_walk_a: assert property (dma && req_has_pasid |=> rsp_block
    || rsp_walk inside {pcd_pkg::PCD_WALK_FIRST_ONLY, pcd_pkg::PCD_WALK_NESTED})
    else $error("pasid request walked as legacy");
  legacy_walk_a: assert property (dma && !req_has_pasid |=>
    rsp_block || rsp_walk == pcd_pkg::PCD_WALK_LEGACY)
    else $error("plain request not legacy");
  blocked_none_a: assert property (rsp_valid && rsp_block |->
    rsp_walk == pcd_pkg::PCD_WALK_NONE && !rsp_use_state_table)
    else $error("blocked request still walked");
  page_nowalk_a: assert property (req_valid && req_kind == pcd_pkg::PCD_KIND_PAGE_REQ |=>
    rsp_walk == pcd_pkg::PCD_WALK_NONE && !rsp_use_state_table)
    else $error("page request walked");
  state_upd_a: assert property (req_valid && req_kind == pcd_pkg::PCD_KIND_STATE_UPD |=>
    rsp_block != rsp_use_state_table)
    else $error("state update neither blocked nor processed");
  rsvd_kind_a: assert property (req_valid && req_kind == pcd_pkg::PCD_KIND_RSVD |=> rsp_block)
    else $error("reserved kind not blocked");
  fault_only_a: assert property (rsp_fault_report |-> rsp_valid && rsp_block)
    else $error("fault report without a blocked answer");

  cover property (dma && req_has_pasid ##1 rsp_walk == pcd_pkg::PCD_WALK_NESTED);
  cover property (rsp_use_state_table);
  cover property (rsp_valid && rsp_block && !rsp_fault_report);
endmodule

bind pcd_ctx_decode pcd_ctx_decode_chk pcd_ctx_decode_chk_i
(
  .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
  .req_has_pasid(req_has_pasid), .req_kind(req_kind), .rsp_valid(rsp_valid),
  .rsp_block(rsp_block), .rsp_walk(rsp_walk), .rsp_use_state_table(rsp_use_state_table),
  .rsp_fault_report(rsp_fault_report), .irq(irq)
);

/* pcd_io_dev.sv */
// i/o device model presenting one request at a time to the decoder
// assumes the decoder takes a request at every rising edge with req_valid high
module pcd_io_dev
(
  output logic               req_valid,
  output logic               req_has_pasid,
  output pcd_pkg::pcd_kind_t req_kind,
  input  wire logic          sys_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    req_valid = 1'b0;
    req_has_pasid = 1'b0;
    req_kind = pcd_pkg::PCD_KIND_DMA;
  end
  task automatic issue(input pcd_pkg::pcd_kind_t k, input logic p);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_has_pasid <= p;
    req_kind <= k;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    // stale qualifiers are inverted so a decoder that ignores valid is caught
    req_has_pasid <= !p;
    req_kind <= pcd_pkg::pcd_kind_t'(~k);
  endtask
endmodule

/* tb_pcd_ctx_decode.sv */
// self-checking bench of the context-entry decoder over ahb-lite
// assumes hready is the decoder's own hreadyout and word transfers only
module tb_pcd_ctx_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk = 1'b0;
  logic               nrst, hsel, hwrite, hready;
  logic [31:0]        haddr, hwdata, hrdata;
  logic [1:0]         htrans;
  logic               req_valid, req_has_pasid, rsp_valid, rsp_block, ust, frep, irq;
  logic               hreadyout, hresp;
  pcd_pkg::pcd_kind_t req_kind;
  pcd_pkg::pcd_walk_t rsp_walk;
  int                 bad_count = 0;
  int                 checks = 0;

  always #25 sys_clk = ~sys_clk;
  assign hready = hreadyout;

  pcd_ctx_decode pcd_ctx_decode_i
  (
    .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
    .req_has_pasid(req_has_pasid), .req_kind(req_kind), .rsp_valid(rsp_valid),
    .rsp_block(rsp_block), .rsp_walk(rsp_walk), .rsp_use_state_table(ust),
    .rsp_fault_report(frep), .irq(irq)
  );
  pcd_io_dev pcd_io_dev_i
  (
    .req_valid(req_valid), .req_has_pasid(req_has_pasid), .req_kind(req_kind),
    .sys_clk(sys_clk)
  );

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // each bus phase ends at the edge where hready is seen high
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        give_verdict();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(a, 1'b1, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(a, 1'b0, 32'h0, r);
    chk(r, e);
  endtask
  // expected {valid, block, walk, state table, fault report}
  function automatic logic [5:0] exp_rsp(input logic [1:0] k, input logic p,
                                         input logic [3:0] c, input logic [1:0] pf);
    logic [1:0] w;
    logic       b;
    w = pcd_pkg::PCD_WALK_NONE;
    b = 1'b1;
    if (pf[0] && k == 2'h0)
    begin
      b = p && !c[0];
      if (!p)
        w = pcd_pkg::PCD_WALK_LEGACY;
      else if (c[0])
        w = c[1] ? pcd_pkg::PCD_WALK_NESTED : pcd_pkg::PCD_WALK_FIRST_ONLY;
    end
    else if (pf[0] && k == 2'h1)
      b = !c[2];
    else if (pf[0] && k == 2'h2)
      b = !(c[3] && c[0]);
    return {1'b1, b, w, pf[0] && k == 2'h2 && !b, b && !pf[1]};
  endfunction
  task automatic req_chk(input logic [1:0] k, input logic p, input logic [3:0] c,
                         input logic [1:0] pf);
    pcd_io_dev_i.issue(pcd_pkg::pcd_kind_t'(k), p);
    #1 chk({26'h0, rsp_valid, rsp_block, rsp_walk, ust, frep}, {26'h0, exp_rsp(k, p, c, pf)});
  endtask

  initial
  begin
    logic [3:0] c;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(pcd_pkg::OFS_CAP, 32'h0000000f);
    rd_chk(pcd_pkg::OFS_EFFECTIVE, 32'h0);
    rd_chk(pcd_pkg::OFS_IRQ_EN, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(pcd_pkg::OFS_ENTRY, 32'h00000f05);
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr(pcd_pkg::OFS_CAP, {28'h0, c});
      rd_chk(pcd_pkg::OFS_ENTRY, {20'h0, c[0], c[1], c[2], c[3], 8'h05});
      rd_chk(pcd_pkg::OFS_EFFECTIVE, {24'h0, 2'h2, c[0] & c[1], c[0] & !c[1],
                                      c[3] & c[0], c[2], c[1] & c[0], c[0]});
      for (int k = 0; k < 8; k++)
        req_chk(k[2:1], k[0], c, 2'h1);
    end
    wr(pcd_pkg::OFS_ENTRY, 32'h00000f01);
    rd_chk(pcd_pkg::OFS_ENTRY, 32'h00000d01);
    req_chk(2'h1, 1'b0, 4'hb, 2'h1);
    wr(pcd_pkg::OFS_ENTRY, 32'h00000f02);
    wr(pcd_pkg::OFS_EFFECTIVE, 32'h000000ff);
    rd_chk(pcd_pkg::OFS_EFFECTIVE, 32'h00000040);
    req_chk(2'h0, 1'b0, 4'hf, 2'h2);
    wr(pcd_pkg::OFS_IRQ_CLR, 32'h0000000f);
    rd_chk(pcd_pkg::OFS_IRQ_STAT, 32'h0);
    req_chk(2'h0, 1'b1, 4'hf, 2'h2);
    rd_chk(pcd_pkg::OFS_IRQ_STAT, 32'h00000008);
    chk({31'h0, irq}, 32'h0);
    wr(pcd_pkg::OFS_IRQ_EN, 32'h00000008);
    #1 chk({31'h0, irq}, 32'h1);
    wr(pcd_pkg::OFS_IRQ_CLR, 32'h00000008);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(pcd_pkg::OFS_IRQ_STAT, 32'h0);
    give_verdict();
  end
endmodule
